// [logic/aoc_channel.sv]
// One alarm channel: ON/OFF delay, latch and output polarity
`timescale 1ns/1ps
`include "aoc_defs.svh"
module aoc_channel
  import aoc_pkg::*;
#(
  parameter int DLY_W = 10
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rstn,
  input  wire logic             i_tick,
  input  wire logic             i_raw,
  input  wire logic [3:0]       i_type,
  input  wire logic             i_latch_allowed,
  input  wire logic             i_latch_en,
  input  wire logic             i_open_alm,
  input  wire logic             i_cancel,
  input  wire logic             i_cfg_level,
  input  wire logic [DLY_W-1:0] i_on_dly,
  input  wire logic [DLY_W-1:0] i_off_dly,
  output logic                  o_alarm,
  output logic                  o_latched,
  output logic                  o_drive
);
  aoc_state_type    state_q;
  logic [DLY_W-1:0] cnt_q;
  logic             latch_q;
  logic             rel_pend_q;
  logic             no_delay;
  logic             cond;

  ////////////////////////////////////////////////////////////////////////
  // Delays are bypassed for types without delay support
  assign no_delay = (i_type == `AOC_TYPE_NONE) ||
                    (i_type == `AOC_TYPE_LOOP) ||
                    (i_type == `AOC_TYPE_THIRTEEN); // RULE11
  assign cond = i_raw && (i_type != `AOC_TYPE_NONE);

  // Delay state machine; counts in whole seconds on the tick
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= AOC_IDLE; // RULE13
      cnt_q   <= '0;
    end else begin
      case (state_q)
        AOC_IDLE: begin
          if (cond) begin
            if (no_delay || i_on_dly == '0) begin
              state_q <= AOC_ACT; // RULE8
            end else begin
              state_q <= AOC_ONDLY; // RULE7
              cnt_q   <= i_on_dly;
            end
          end else if (i_cancel && latch_q && !rel_pend_q && !no_delay &&
                       i_off_dly != '0) begin
            // Held latch with the condition gone: cancel runs the OFF delay
            state_q <= AOC_OFFDLY; // RULE4
            cnt_q   <= i_off_dly;
          end
        end
        AOC_ONDLY: begin
          if (!cond) begin
            state_q <= AOC_IDLE;
          end else if (i_tick) begin
            if (cnt_q == DLY_W'(1)) begin
              state_q <= AOC_ACT; // RULE7
            end
            cnt_q <= cnt_q - DLY_W'(1);
          end
        end
        AOC_ACT: begin
          // A latch cancel also runs through the OFF delay
          if (!cond || rel_pend_q) begin
            if (no_delay || i_off_dly == '0) begin
              state_q <= AOC_IDLE; // RULE10
            end else begin
              state_q <= AOC_OFFDLY; // RULE9 RULE4
              cnt_q   <= i_off_dly;
            end
          end
        end
        AOC_OFFDLY: begin
          if (cond && !rel_pend_q && !latch_q) begin
            state_q <= AOC_ACT;
          end else if (i_tick) begin
            if (cnt_q == DLY_W'(1)) begin
              state_q <= AOC_IDLE; // RULE9
            end
            cnt_q <= cnt_q - DLY_W'(1);
          end
        end
        default: begin
          state_q <= AOC_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Latch: set when delayed alarm asserts; held until cancel and expiry
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      latch_q    <= 1'b0; // RULE13
      rel_pend_q <= 1'b0;
    end else if (i_cfg_level) begin
      latch_q    <= 1'b0; // RULE2
      rel_pend_q <= 1'b0;
    end else begin
      if (state_q == AOC_ACT && i_latch_en && i_latch_allowed) begin
        latch_q <= 1'b1; // RULE1 RULE5
      end
      if (i_cancel && latch_q) begin
        rel_pend_q <= 1'b1; // RULE1
      end
      // Release only when the OFF delay has run out
      if (rel_pend_q && state_q == AOC_IDLE) begin
        latch_q    <= 1'b0; // RULE4
        rel_pend_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output: forced off in configuration levels, polarity applied
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_alarm <= 1'b0;
      o_drive <= 1'b0;
    end else begin
      o_alarm <= !i_cfg_level &&
                 (state_q == AOC_ACT || state_q == AOC_OFFDLY ||
                  latch_q); // RULE3 RULE2
      o_drive <= (!i_cfg_level &&
                  (state_q == AOC_ACT || state_q == AOC_OFFDLY ||
                   latch_q)) ^ i_open_alm; // RULE12 RULE3
    end
  end
  assign o_latched = latch_q;
endmodule

// [logic/aoc_defs.svh]
// Constants for the alarm output conditioner
`ifndef AOC_DEFS_SVH
`define AOC_DEFS_SVH
`define AOC_CLK_HZ        200000000
`define AOC_TICK_SEC      1
`define AOC_TICK_CYC      (`AOC_CLK_HZ * `AOC_TICK_SEC)
`define AOC_DLY_MAX       999
`define AOC_TYPE_NONE     4'h0
`define AOC_TYPE_LOOP     4'hC
`define AOC_TYPE_THIRTEEN 4'hD
`define AOC_A_CTRL        12'h000
`define AOC_A_LATCH_EN    12'h004
`define AOC_A_OPEN_ALM    12'h008
`define AOC_A_CANCEL      12'h00C
`define AOC_A_LEVEL       12'h010
`define AOC_A_STATUS      12'h014
`define AOC_A_IRQ_STAT    12'h018
`define AOC_A_IRQ_MASK    12'h01C
`define AOC_A_OUT         12'h020
`define AOC_A_TYPE0       12'h040
`define AOC_A_ON0         12'h060
`define AOC_A_OFF0        12'h080
`define AOC_RST_DLY       10'h000
`define AOC_RST_TYPE      4'h1
`endif

// [logic/aoc_pkg.sv]
// Types for the alarm output conditioner
package aoc_pkg;
  typedef enum logic [1:0] {
    AOC_IDLE  = 2'b00,
    AOC_ONDLY = 2'b01,
    AOC_ACT   = 2'b11,
    AOC_OFFDLY = 2'b10
  } aoc_state_type;
endpackage

// [logic/aoc_top.sv]
// Alarm output conditioner top: APB registers, tick and four channels
//
// Operation
// RULE1 - A latched channel holds its alarm until power cycle or a cancel.
// RULE2 - Entering a configuration level forces latched outputs off.
// RULE3 - While latched, the output stays in its alarm polarity.
// RULE4 - With nonzero OFF delay, a cancel releases only after it expires.
// RULE5 - Latch works on ch1 except type 0, ch2-4 except types 0 and 12.
// RULE6 - Each of four channels has its own ON and OFF delay.
// RULE7 - Output stays off until the ON delay (0-999 s) has elapsed.
// RULE8 - An ON delay of zero disables it; zero is the default.
// RULE9 - Output stays on until the OFF delay (0-999 s) has elapsed.
// RULE10 - An OFF delay of zero disables it; zero is the default.
// RULE11 - Delays do not apply to alarm types 0, 12 and 13.
// RULE12 - Open-in-alarm channels invert the alarm; close-in passes it.
// RULE13 - A one-second tick drives the counters; reset clears all state.
//
// Register map: byte offsets of 32-bit words, no wait states
// 0x000 control: bit0 enables the key cancel, bit1 the event cancel
// 0x004 latch enable, one bit per channel
// 0x008 open-in-alarm, one bit per channel
// 0x00C writing bit0 as one issues a software latch cancel
// 0x010 configuration level: bit0 forces outputs off, drops latches
// 0x014 status: bits 3:0 alarm active, bits 7:4 latched
// 0x018 interrupt status, write one to clear
// 0x01C interrupt mask, same layout as the status
// 0x020 readback of the output drive
// 0x040 + 4 * ch: alarm type of channel ch
// 0x060 + 4 * ch: ON delay of channel ch, whole seconds
// 0x080 + 4 * ch: OFF delay of channel ch, whole seconds
// Unmapped reads return zero; unmapped writes are dropped.
//
// Interfaces
// The register bus is APB with pready tied high and pslverr tied low.
// Raw alarms come from the comparators, one bit per channel.
// Output drives go to the auxiliary output drivers; one means closed.
//
// Timing
// Raw alarms are taken as synchronous to the system clock; with no
// delay a change reaches the output pins two clocks later.
// The tick runs free, so the first second of a delay may be short: a
// delay of N seconds ends between N - 1 and N seconds after its start.
// Delays above the maximum are clamped, not refused, so the bus never
// has to return an error.
// Read data is loaded in the setup cycle and stands for the access
// cycle only; it reads zero at every other time.
//
// Reset
// Reset clears every latch, counter and setting; types come up as 1
// and both delays as zero, so a channel works with no set-up at all.
//
// Hazards
// A configuration level wins over every other input of a channel and
// drops its latch as well, but not its delay state, so leaving the level
// revives an old alarm for the rest of an OFF delay still running.
// A set of interrupt status in the same cycle as a write-one-to-clear
// wins, so no alarm edge is ever lost.
// A cancel with no latch held is ignored and not remembered; cancel
// sources are ORed; key and event each have their own enable so that an unused key
// or event input cannot drop a latch by accident.
// A latch release waits for the OFF delay even when the condition had
// cleared long before the cancel, so the pin behaves the same way in
// both cases.
// Settings written while a delay runs apply at its next start; a count
// in progress is not reloaded.
//
// Limitations
// Delays count whole seconds only; there is no finer unit.
// All channels share one tick, so two delays of equal length started
// within the same second end in the same cycle.
// Types 12 and 13 bypass both delays; type 0 never raises an alarm.
// Channel 1 may latch a type 12 alarm; channels 2 to 4 may not.
// The bus has no byte strobes; every write replaces the whole word.
`timescale 1ns/1ps
`include "aoc_defs.svh"
module aoc_top
  import aoc_pkg::*;
#(
  parameter int N_CH     = 4,
  parameter int DLY_W    = 10,
  parameter int TICK_CYC = `AOC_TICK_CYC
) (
  input  wire logic            i_clk_sys,
  input  wire logic            i_rstn,
  input  wire logic            i_psel,
  input  wire logic            i_penable,
  input  wire logic            i_pwrite,
  input  wire logic [11:0]     i_paddr,
  input  wire logic [31:0]     i_pwdata,
  output logic [31:0]          o_prdata,
  output logic                 o_pready,
  output logic                 o_pslverr,
  input  wire logic [N_CH-1:0] i_alarm_raw,
  input  wire logic            i_front_function_key,
  input  wire logic            i_event_cancel,
  output logic [N_CH-1:0]      o_aux_out,
  output logic                 o_irq
);
  // Tick generator
  logic [31:0]      tick_cnt_q;
  logic             tick;

  // Software settings and cancel sources
  logic [N_CH-1:0]  latch_en_q;
  logic [N_CH-1:0]  open_alm_q;
  logic             lcf_key_en_q;
  logic             lcf_evt_en_q;
  logic             level_q;
  logic             sw_cancel;
  logic             cancel;

  // Per-channel settings
  logic [3:0]       type_q   [N_CH];
  logic [DLY_W-1:0] on_dly_q [N_CH];
  logic [DLY_W-1:0] off_dly_q[N_CH];

  // Channel status and interrupt state
  logic [N_CH-1:0]  alarm;
  logic [N_CH-1:0]  alarm_prev_q;
  logic [N_CH-1:0]  latched;
  logic [N_CH-1:0]  allowed;
  logic [N_CH-1:0]  irq_stat_q;
  logic [N_CH-1:0]  irq_mask_q;
  logic [N_CH-1:0]  rise;

  // Bus decode
  logic             wr_en;
  logic             rd_en;

  ////////////////////////////////////////////////////////////////////////
  // One-second tick from the system clock; 32 bits hold any clock rate
  // up to about four gigahertz, and the tick is one cycle wide so that
  // each channel counts it exactly once
  assign tick = (tick_cnt_q == 32'(TICK_CYC - 1)); // RULE13
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      tick_cnt_q <= 32'h0000_0000;
    end else if (tick) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave: zero-wait; writes land on the access edge, while reads
  // are loaded at the setup edge so the data stands through the access
  assign wr_en     = i_psel && i_penable && i_pwrite;
  assign rd_en     = i_psel && !i_penable && !i_pwrite;
  assign o_pready  = 1'b1;
  assign o_pslverr = 1'b0;
  assign sw_cancel = wr_en && (i_paddr == `AOC_A_CANCEL) && i_pwdata[0];

  // Latch cancel sources: key, event input, or software
  // The software cancel is a one-cycle pulse from a bus write; key and
  // event input are levels, and a held key starts no second OFF delay
  assign cancel = (lcf_key_en_q && i_front_function_key) ||
                  (lcf_evt_en_q && i_event_cancel) || sw_cancel; // RULE1

  // Control registers
  // Writes to read-only or unmapped offsets fall through the default
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      latch_en_q   <= '0;
      open_alm_q   <= '0;
      lcf_key_en_q <= 1'b0;
      lcf_evt_en_q <= 1'b0;
      level_q      <= 1'b0;
      irq_mask_q   <= '0;
    end else if (wr_en) begin
      case (i_paddr)
        `AOC_A_CTRL: begin
          lcf_key_en_q <= i_pwdata[0];
          lcf_evt_en_q <= i_pwdata[1];
        end
        `AOC_A_LATCH_EN: latch_en_q <= i_pwdata[N_CH-1:0];
        `AOC_A_OPEN_ALM: open_alm_q <= i_pwdata[N_CH-1:0];
        `AOC_A_LEVEL:    level_q    <= i_pwdata[0];
        `AOC_A_IRQ_MASK: irq_mask_q <= i_pwdata[N_CH-1:0];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-channel settings and conditioners
  // One generate loop keeps the channels identical but for the latch rule of channel 1
  genvar g;
  generate
    for (g = 0; g < N_CH; g++) begin : g_ch
      // Independent delay and type registers per channel
      always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
          type_q[g]    <= `AOC_RST_TYPE;
          on_dly_q[g]  <= DLY_W'(`AOC_RST_DLY); // RULE8
          off_dly_q[g] <= DLY_W'(`AOC_RST_DLY); // RULE10
        end else if (wr_en) begin
          // Only the low four bits of the word hold the type
          if (i_paddr == `AOC_A_TYPE0 + 12'(4 * g)) begin
            type_q[g] <= i_pwdata[3:0];
          end
          // Values above 999 are clamped to the maximum
          // so that a stray large write cannot wrap the counter
          if (i_paddr == `AOC_A_ON0 + 12'(4 * g)) begin
            on_dly_q[g] <= (i_pwdata > `AOC_DLY_MAX) ?
                           DLY_W'(`AOC_DLY_MAX) :
                           i_pwdata[DLY_W-1:0]; // RULE6 RULE7
          end
          if (i_paddr == `AOC_A_OFF0 + 12'(4 * g)) begin
            off_dly_q[g] <= (i_pwdata > `AOC_DLY_MAX) ?
                            DLY_W'(`AOC_DLY_MAX) :
                            i_pwdata[DLY_W-1:0]; // RULE6 RULE9
          end
        end
      end

      // Channel 1 excludes type 0 only; others also exclude type 12
      // A latch refused here still lets the alarm itself through
      assign allowed[g] = (type_q[g] != `AOC_TYPE_NONE) &&
                          ((g == 0) ||
                           (type_q[g] != `AOC_TYPE_LOOP)); // RULE5

      // Conditioner; the tick and the cancel are shared by all channels
      aoc_channel #(
        .DLY_W (DLY_W)
      ) u_ch (
        .i_clk_sys       (i_clk_sys),
        .i_rstn          (i_rstn),
        .i_tick          (tick),
        .i_raw           (i_alarm_raw[g]),
        .i_type          (type_q[g]),
        .i_latch_allowed (allowed[g]),
        .i_latch_en      (latch_en_q[g]),
        .i_open_alm      (open_alm_q[g]),
        .i_cancel        (cancel),
        .i_cfg_level     (level_q),
        .i_on_dly        (on_dly_q[g]),
        .i_off_dly       (off_dly_q[g]),
        .o_alarm         (alarm[g]),
        .o_latched       (latched[g]),
        .o_drive         (o_aux_out[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Interrupts: alarm rising edge sets sticky bit; set wins over clear
  // The edge detector starts at zero, the idle level of an alarm
  assign rise = alarm & ~alarm_prev_q;
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      alarm_prev_q <= '0;
      irq_stat_q   <= '0;
    end else begin
      alarm_prev_q <= alarm;
      if (wr_en && i_paddr == `AOC_A_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~i_pwdata[N_CH-1:0]) | rise;
      end else begin
        irq_stat_q <= irq_stat_q | rise;
      end
    end
  end
  // Level interrupt: high while any unmasked status bit is set
  assign o_irq = |(irq_stat_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////
  // Read data; unmapped addresses read zero
  // Per-channel words are found by a loop, since their offsets repeat
  // every four bytes for each channel
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_prdata <= 32'h0000_0000;
    end else begin
      o_prdata <= 32'h0000_0000;
      if (rd_en) begin
        case (i_paddr)
          `AOC_A_CTRL:     o_prdata <= {30'h0, lcf_evt_en_q, lcf_key_en_q};
          `AOC_A_LATCH_EN: o_prdata <= 32'(latch_en_q);
          `AOC_A_OPEN_ALM: o_prdata <= 32'(open_alm_q);
          `AOC_A_LEVEL:    o_prdata <= {31'h0, level_q};
          `AOC_A_STATUS:   o_prdata <= 32'({latched, alarm});
          `AOC_A_IRQ_STAT: o_prdata <= 32'(irq_stat_q);
          `AOC_A_IRQ_MASK: o_prdata <= 32'(irq_mask_q);
          `AOC_A_OUT:      o_prdata <= 32'(o_aux_out);
          default: begin
            for (int k = 0; k < N_CH; k++) begin
              if (i_paddr == `AOC_A_TYPE0 + 12'(4 * k)) begin
                o_prdata <= 32'(type_q[k]);
              end
              if (i_paddr == `AOC_A_ON0 + 12'(4 * k)) begin
                o_prdata <= 32'(on_dly_q[k]);
              end
              if (i_paddr == `AOC_A_OFF0 + 12'(4 * k)) begin
                o_prdata <= 32'(off_dly_q[k]);
              end
            end
          end
        endcase
      end
    end
  end
endmodule

// [tb/aoc_assertions.sv]
// Port checker for the alarm output conditioner
`timescale 1ns/1ps
`include "aoc_defs.svh"
module aoc_assertions #(
  parameter int N_CH = 4
) (
  input wire logic            i_clk_sys,
  input wire logic            i_rstn,
  input wire logic            i_psel,
  input wire logic            i_penable,
  input wire logic            i_pwrite,
  input wire logic [11:0]     i_paddr,
  input wire logic [31:0]     i_pwdata,
  input wire logic [31:0]     o_prdata,
  input wire logic            o_pready,
  input wire logic            o_pslverr,
  input wire logic [N_CH-1:0] o_aux_out,
  input wire logic            o_irq
);
  logic [N_CH-1:0] open_q;
  logic [3:0]      mask_q;
  logic            lvl_q;
  logic            rd_set;
  // Shadow settings; a write lands at the access edge, as in the slave
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      open_q <= '0;
      mask_q <= 4'h0;
      lvl_q  <= 1'b0;
    end else if (i_psel && i_penable && i_pwrite) begin
      if (i_paddr == `AOC_A_OPEN_ALM)
        open_q <= i_pwdata[N_CH-1:0];
      if (i_paddr == `AOC_A_IRQ_MASK)
        mask_q <= i_pwdata[3:0];
      if (i_paddr == `AOC_A_LEVEL)
        lvl_q <= i_pwdata[0];
    end
  end
  assign rd_set = i_psel && !i_penable && !i_pwrite;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////////////////////////
  a_ready_high: assert property (o_pready)
    else $error("pready low");
  a_no_slverr: assert property (!o_pslverr)
    else $error("pslverr high");
  a_prdata_idle: assert property (
    !(i_psel && i_penable) |-> o_prdata == 32'h0)
    else $error("read data outside access phase");
  a_out_readback: assert property (rd_set && i_paddr == `AOC_A_OUT
    |=> o_prdata == 32'($past(o_aux_out)))
    else $error("output readback wrong");
  a_unmapped_zero: assert property (rd_set && i_paddr >= 12'h0A0
    |=> o_prdata == 32'h0)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property (
    $rose(i_rstn) |-> o_aux_out == '0 && !o_irq)
    else $error("outputs active after reset");
  a_mask_irq: assert property (mask_q == 4'h0 |-> !o_irq)
    else $error("masked interrupt raised");
  // Settling time of four edges covers the level and output registers
  a_level_off: assert property (
    (lvl_q && $stable(open_q))[*4] |-> o_aux_out == open_q)
    else $error("output not off in configuration level");
endmodule

// [tb/aoc_far_model.sv]
// Far side model: alarm comparators and auxiliary output relays
`timescale 1ns/1ps
module aoc_far_model (
  input  wire logic       i_clk_sys,
  input  wire logic [3:0] i_excess,
  input  wire logic [3:0] i_aux_out,
  output logic [3:0]      o_alarm_raw,
  output logic [3:0]      o_contact
);
  ////////////////////////////////////////////////////////////
  // Comparator verdict is registered, so raw alarms move on edges only
  always @(posedge i_clk_sys) begin
    o_alarm_raw <= i_excess;
  end
  // Relay contact follows the drive; 1 means closed
  assign o_contact = i_aux_out;
endmodule

// [tb/test_alarm_output_conditioner.sv]
// Self-checking bench of the alarm output conditioner
`timescale 1ns/1ps
`include "aoc_defs.svh"
module test_alarm_output_conditioner;
  localparam int TK = 10;
  logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0;
  logic        pwr = 1'b0, key = 1'b0, evt = 1'b0, pready, pslverr, irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  want = 4'h0, raw, aux, cont;
  integer      seed = 60;
  int          n_mismatch = 0, n_compared = 0, cyc = 0;
  int          t_hit[4], on[4], off[4];
  aoc_top #(.TICK_CYC(TK)) i_dut (
    .i_clk_sys(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_alarm_raw(raw), .i_front_function_key(key),
    .i_event_cancel(evt), .o_aux_out(aux), .o_irq(irq));
  aoc_far_model i_far (.i_clk_sys(clk), .i_excess(want),
    .i_aux_out(aux), .o_alarm_raw(raw), .o_contact(cont));
  initial forever #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One APB transfer; read data is taken with pready at the final edge
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Values read just after the edge are those sampled at that edge
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic rdc(logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("read data", e, rd);
  endtask
  function automatic logic [11:0] ad(logic [11:0] b, int g);
    return b + 12'(4 * g);
  endfunction
  // First tick is partial, so a delay of n may end up to a tick early
  function automatic logic in_win(int t, int n);
    return t >= 0 && t >= (n - 1) * TK - 3 && t <= n * TK + 5;
  endfunction
  // Records the first cycle at which each contact reaches its level
  task automatic go(logic [3:0] v, logic [3:0] o);
    @(posedge clk);
    want <= v;
    for (int g = 0; g < 4; g++) t_hit[g] = -1;
    for (int c = 0; c < 60; c++) begin
      @(negedge clk);
      for (int g = 0; g < 4; g++)
        if (t_hit[g] < 0 && cont[g] === (v[g] ^ o[g])) t_hit[g] = c;
    end
  endtask
  task automatic latch_all;
    go(4'hF, 4'h8);
    go(4'h0, 4'h8);
    chk("held", 32'h5, 32'(aux));
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    for (int g = 0; g < 4; g++) begin
      rdc(ad(`AOC_A_TYPE0, g), 32'h1);
      rdc(ad(`AOC_A_ON0, g), 32'h0);
      rdc(ad(`AOC_A_OFF0, g), 32'h0);
    end
    rdc(12'h100, 32'h0);
    // Pass 0 defaults, pass 1 random delays, pass 2 delay-free types
    for (int p = 0; p < 3; p++) begin
      for (int g = 0; g < 4; g++) begin
        if (p == 1) begin
          on[g]  = 1 + {$random(seed)} % 4;
          off[g] = 1 + {$random(seed)} % 4;
          apb(1'b1, ad(`AOC_A_ON0, g), on[g]);
          apb(1'b1, ad(`AOC_A_OFF0, g), off[g]);
        end
        if (p == 2)
          apb(1'b1, ad(`AOC_A_TYPE0, g), g[0] ? 32'hC : 32'hD);
      end
      go(4'hF, 4'h0);
      for (int g = 0; g < 4; g++)
        chk("on", 1, in_win(t_hit[g], p == 1 ? on[g] : 0));
      go(4'h0, 4'h0);
      for (int g = 0; g < 4; g++)
        chk("off", 1, in_win(t_hit[g], p == 1 ? off[g] : 0));
    end
    // Latching set-up: channel 2 at type 12 may not latch; channel 3
    // has an OFF delay, since types 12 and 13 bypass delays
    for (int g = 0; g < 4; g++) begin
      apb(1'b1, ad(`AOC_A_TYPE0, g), g < 2 ? 32'hC : 32'h1);
      apb(1'b1, ad(`AOC_A_OFF0, g), g == 2 ? 32'h2 : 32'h0);
      apb(1'b1, ad(`AOC_A_ON0, g), 32'h0);
    end
    apb(1'b1, `AOC_A_LATCH_EN, 32'hF);
    apb(1'b1, `AOC_A_CTRL, 32'h3);
    apb(1'b1, `AOC_A_OPEN_ALM, 32'h8);
    apb(1'b1, `AOC_A_IRQ_MASK, 32'h1);
    for (int s = 0; s < 3; s++) begin
      latch_all();
      if (s < 2) begin
        @(posedge clk);
        key <= (s == 0);
        evt <= (s == 1);
        repeat (2) @(posedge clk);
        key <= 1'b0;
        evt <= 1'b0;
        go(4'h0, 4'h8);
        chk("off delay", 1, in_win(t_hit[2], 2));
        for (int g = 0; g < 4; g++)
          if (g != 2)
            chk("cancel", 1, in_win(t_hit[g], 0));
      end else begin
        apb(1'b1, `AOC_A_LEVEL, 32'h1);
        repeat (6) @(posedge clk);
        chk("level", 32'h8, 32'(aux));
        apb(1'b1, `AOC_A_LEVEL, 32'h0);
        repeat (6) @(posedge clk);
        chk("level exit", 32'h8, 32'(aux));
      end
    end
    chk("irq", 1, irq);
    // Only the bit written as one clears; channels 2 to 4 stay set
    apb(1'b1, `AOC_A_IRQ_STAT, 32'h1);
    rdc(`AOC_A_IRQ_STAT, 32'hE);
    chk("irq", 0, irq);
    // Reset in mid-run drops every latch
    latch_all();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    chk("reset", 32'h0, 32'(aux));
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk("after reset", 32'h0, 32'(aux));
    rdc(`AOC_A_OUT, 32'h0);
    give_verdict();
  end
endmodule
bind aoc_top aoc_assertions #(.N_CH(N_CH)) i_chk (
  .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_aux_out(o_aux_out), .o_irq(o_irq));
